// >>> dac_control_logic.sv
// Top of the converter control block: classic Wishbone register slave,
// sleep request synchronisers and the outputs to the analog core.
// Assumes a Wishbone master on MCLK and sleep requests from any domain.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dac_control_logic #(
  parameter int ADR_W      = 8,                       // Byte address width
  parameter int STARTUP_NS = dac_pkg::STARTUP_NS_DEF  // Start-up time
) (
  input  wire logic             MCLK,                 // Peripheral clock
  input  wire logic             RESET,                // Sync reset, high
  input  wire logic [ADR_W-1:0] WB_ADR_I,             // Byte address
  input  wire logic [31:0]      WB_DAT_I,             // Write data
  output logic      [31:0]      WB_DAT_O,             // Read data
  input  wire logic [3:0]       WB_SEL_I,             // Byte lanes
  input  wire logic             WB_WE_I,              // Write strobe
  input  wire logic             WB_STB_I,             // Strobe
  input  wire logic             WB_CYC_I,             // Cycle
  output logic                  WB_ACK_O,             // Acknowledge
  output logic                  WB_ERR_O,             // Unmapped access
  input  wire logic             STANDBY_REQ,          // Standby sleep
  input  wire logic             POWERDOWN_REQ,        // Power-down sleep
  output logic                  CORE_ON,              // Converter power
  output logic                  BUFFER_ON,            // Pin buffer power
  output logic                  INTERNAL_READY,       // Output usable
  output logic [dac_pkg::CODE_W-1:0] CODE_OUT,        // Code to core
  output logic                  CONV_START            // Conversion pulse
);
  import dac_pkg::*;

  // Start-up interval in cycles, least time so rounded up
  localparam int WARM_CYCLES_RAW =
    (STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WARM_CYCLES =
    (WARM_CYCLES_RAW < 1) ? 1 : WARM_CYCLES_RAW;

  initial begin
    if (ADR_W < 4)
      $error("ADR_W must reach the highest register word");
    if (STARTUP_NS < 0)
      $error("STARTUP_NS must not be negative");
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Word index of a byte address; the two low bits select a byte lane
  // and are ignored, since each register sits in one aligned word
  function automatic logic [3:0] word_index(input logic [ADR_W-1:0] a);
    logic [ADR_W-1:0] w;
    w = a >> 2;
    word_index = w[3:0];
  endfunction

  // True when the upper address bits are clear and the index is mapped
  function automatic logic is_mapped(input logic [ADR_W-1:0] a);
    logic [ADR_W-1:0] w;
    logic [3:0]       i;
    w = a >> 2;
    i = w[3:0];
    is_mapped = ((w >> 4) == '0) &&
                (i == IDX_CONTROL || i == IDX_CODE || i == IDX_STATUS);
  endfunction

  // Split code register into the ten-bit converter code
  function automatic logic [CODE_W-1:0] pack_code(input logic [15:0] r);
    pack_code = {r[15:CODE_HI_POS], r[CODE_HI_POS-1:CODE_LO_POS]};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  dac_ctl_if         ctl ();
  logic [7:0]        control;
  logic [15:0]       code_reg;
  logic [7:0]        status;
  logic              req;
  logic              commit;
  logic [3:0]        req_idx;
  logic              req_ok;
  logic [1:0]        stdby_sync;
  logic [1:0]        pdown_sync;
  logic              hi_pulse;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone request decode

  // A request is live while cycle and strobe are both high
  assign req     = WB_CYC_I && WB_STB_I;
  assign req_idx = word_index(WB_ADR_I);
  assign req_ok  = is_mapped(WB_ADR_I);

  // A write takes effect at the edge where the master sees ack,
  // so a held write is applied exactly once
  assign commit  = req && WB_WE_I && WB_ACK_O;

  // Answer one cycle after the request appears and drop it the next
  // cycle, which leaves a gap for the master to release the request
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      WB_ACK_O <= 1'b0;
      WB_ERR_O <= 1'b0;
    end else begin
      WB_ACK_O <= req && req_ok && !WB_ACK_O && !WB_ERR_O;
      WB_ERR_O <= req && !req_ok && !WB_ACK_O && !WB_ERR_O;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control register

  // Only the three defined bits store; the rest stay zero
  always_ff @(posedge MCLK) begin
    if (RESET)
      control <= CTL_RESET;
    else if (commit && req_idx == IDX_CONTROL && WB_SEL_I[0])
      control <= WB_DAT_I[7:0] & CTL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // Code register, written byte by byte

  // Low byte keeps only its two code bits and starts nothing
  always_ff @(posedge MCLK) begin
    if (RESET)
      code_reg[7:0] <= CODE_RESET[7:0];
    else if (commit && req_idx == IDX_CODE && WB_SEL_I[0])
      code_reg[7:0] <= WB_DAT_I[7:0] & CODE_MASK[7:0];
  end

  // High byte holds the eight upper code bits
  always_ff @(posedge MCLK) begin
    if (RESET)
      code_reg[15:8] <= CODE_RESET[15:8];
    else if (commit && req_idx == IDX_CODE && WB_SEL_I[1])
      code_reg[15:8] <= WB_DAT_I[15:8];
  end

  // A high byte write marks the code complete; a word write of both
  // lanes lands both halves in the same cycle, so the pair stays whole
  always_ff @(posedge MCLK) begin
    if (RESET)
      hi_pulse <= 1'b0;
    else
      hi_pulse <= commit && req_idx == IDX_CODE && WB_SEL_I[1];
  end

  ////////////////////////////////////////////////////////////////////////
  // Status register: live view of the sequencer

  always_comb begin
    status               = 8'h00;
    status[ST_CORE_BIT]  = ctl.core_on;
    status[ST_BUF_BIT]   = ctl.buf_on;
    status[ST_READY_BIT] = ctl.ready;
    status[ST_WARM_BIT]  = ctl.warming;
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, taken on the request edge so it stands with ack

  // Reserved and unused bits read as zero; an unmapped index reads zero, an address with upper bits set reads its aliased register
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (req && !WB_WE_I && !WB_ACK_O && !WB_ERR_O) begin
      case (req_idx)
        IDX_CONTROL: WB_DAT_O <= {24'h00_0000, control};
        IDX_CODE:    WB_DAT_O <= {16'h0000, code_reg};
        IDX_STATUS:  WB_DAT_O <= {24'h00_0000, status};
        default:     WB_DAT_O <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep request synchronisers

  // Sleep requests come from the power manager in another domain; the
  // first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      stdby_sync <= 2'b00;
      pdown_sync <= 2'b00;
    end else begin
      stdby_sync <= {stdby_sync[0], STANDBY_REQ};
      pdown_sync <= {pdown_sync[0], POWERDOWN_REQ};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Connections to the sequencer

  // Software is expected to write a first code before turning on; the
  // stored code is what the first conversion takes either way
  assign ctl.conv_on    = control[CTL_ON_BIT];
  assign ctl.buf_bit    = control[CTL_BUF_BIT];
  assign ctl.stdby_run  = control[CTL_STDBY_BIT];
  assign ctl.standby    = stdby_sync[1];
  assign ctl.powerdown  = pdown_sync[1];
  assign ctl.hi_written = hi_pulse;
  assign ctl.code       = pack_code(code_reg);

  // Sequencer owns power, start-up and conversion timing
  dac_sequencer #(
    .WARM_CYCLES (WARM_CYCLES)
  ) u_seq (
    .clk      (MCLK),
    .rst      (RESET),
    .ctl      (ctl.seq),
    .code_out (CODE_OUT),
    .start    (CONV_START)
  );

  ////////////////////////////////////////////////////////////////////////
  // Power outputs to the analog core and the pin buffer

  // The pin's digital input must already be off when the buffer drives
  // it; that is left to software and the port logic
  assign CORE_ON        = ctl.core_on;
  assign BUFFER_ON      = ctl.buf_on;
  assign INTERNAL_READY = ctl.ready;

endmodule
`default_nettype wire

// >>> dac_pkg.sv
// Shared constants for the converter control block: register indexes,
// field positions, reset values, sequencer states and timing.
// Assumes a Wishbone byte address in which each register takes one word.
package dac_pkg;

  // Register indexes; byte address is four times the index
  localparam logic [3:0] IDX_CONTROL = 4'h0;
  localparam logic [3:0] IDX_CODE    = 4'h2;
  localparam logic [3:0] IDX_STATUS  = 4'h3;

  // Control register fields
  localparam int CTL_ON_BIT      = 0;
  localparam int CTL_BUF_BIT     = 6;
  localparam int CTL_STDBY_BIT   = 7;
  localparam logic [7:0] CTL_RESET  = 8'h00;
  localparam logic [7:0] CTL_MASK   = 8'hC1;

  // Code register fields: two low bits in 7:6, eight high bits in 15:8
  localparam int CODE_W          = 10;
  localparam int CODE_LO_POS     = 6;
  localparam int CODE_HI_POS     = 8;
  localparam logic [15:0] CODE_RESET = 16'h0000;
  localparam logic [15:0] CODE_MASK  = 16'hFFC0;

  // Status register fields
  localparam int ST_CORE_BIT     = 0;
  localparam int ST_BUF_BIT      = 1;
  localparam int ST_READY_BIT    = 2;
  localparam int ST_WARM_BIT     = 3;

  // Timing
  localparam int CLK_PERIOD_PS   = 4000;
  localparam int STARTUP_NS_DEF  = 1000;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    SEQ_OFF  = 3'b001,
    SEQ_WARM = 3'b010,
    SEQ_RUN  = 3'b100
  } seq_state_e;

endpackage

// >>> dac_ctl_if.sv
// Carrier between the register front end and the power sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface dac_ctl_if;
  import dac_pkg::*;
  logic              conv_on;      // Converter on bit
  logic              buf_bit;      // Output buffer bit
  logic              stdby_run;    // Standby run bit
  logic              standby;      // Synchronised standby sleep
  logic              powerdown;    // Synchronised power-down sleep
  logic              hi_written;   // High byte of code written, pulse
  logic [CODE_W-1:0] code;         // Stored code
  logic              core_on;      // Converter powered
  logic              buf_on;       // Output buffer powered
  logic              warming;      // Start-up interval running
  logic              ready;        // Output available internally

  modport regs (output conv_on, buf_bit, stdby_run, standby, powerdown,
                output hi_written, code,
                input  core_on, buf_on, warming, ready);
  modport seq  (input  conv_on, buf_bit, stdby_run, standby, powerdown,
                input  hi_written, code,
                output core_on, buf_on, warming, ready);
endinterface
`default_nettype wire

// >>> dac_sequencer.sv
// Power and conversion sequencer for the converter core and pin buffer.
// Assumes sleep requests are already synchronised to MCLK.
`timescale 1ns/1ps
`default_nettype none
module dac_sequencer #(
  parameter int WARM_CYCLES = 250                    // Start-up length
) (
  input  wire logic          clk,                    // Peripheral clock
  input  wire logic          rst,                    // Sync reset, high
  dac_ctl_if.seq             ctl,                    // Register side
  output logic [dac_pkg::CODE_W-1:0] code_out,       // Code to core
  output logic               start                   // Conversion pulse
);
  import dac_pkg::*;

  localparam int CNT_W = $clog2(WARM_CYCLES + 1);

  initial begin
    if (WARM_CYCLES < 1)
      $error("WARM_CYCLES must be at least one");
  end

  seq_state_e         state;
  seq_state_e         next_state;
  logic [CNT_W-1:0]   warm_cnt;
  logic               awake_ok;

  ////////////////////////////////////////////////////////////////////////
  // Power permission: standby stops only without standby run
  assign awake_ok = ctl.conv_on && !ctl.powerdown &&
                    !(ctl.standby && !ctl.stdby_run);

  // Next state
  always_comb begin
    next_state = state;
    case (state)
      SEQ_OFF:  if (awake_ok) next_state = SEQ_WARM;
      SEQ_WARM: begin
        if (!awake_ok)
          next_state = SEQ_OFF;
        else if (warm_cnt == CNT_W'(WARM_CYCLES - 1))
          next_state = SEQ_RUN;
      end
      SEQ_RUN:  if (!awake_ok) next_state = SEQ_OFF;
      default:  next_state = SEQ_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst)
      state <= SEQ_OFF;
    else
      state <= next_state;
  end

  // Start-up counter, restarts on every power-up
  always_ff @(posedge clk) begin
    if (rst || state != SEQ_WARM)
      warm_cnt <= '0;
    else
      warm_cnt <= warm_cnt + CNT_W'(1);
  end

  ////////////////////////////////////////////////////////////////////////
  // Conversion: on entry to run the stored code is taken, so a code
  // written while off is converted once the core is up
  always_ff @(posedge clk) begin
    if (rst) begin
      code_out <= '0;
      start    <= 1'b0;
    end else if (state == SEQ_WARM && next_state == SEQ_RUN) begin
      code_out <= ctl.code;
      start    <= 1'b1;
    end else if (state == SEQ_RUN && next_state == SEQ_RUN &&
                 ctl.hi_written) begin
      code_out <= ctl.code;
      start    <= 1'b1;
    end else begin
      start    <= 1'b0;
    end
  end

  // Power outputs; the buffer follows its bit only while the core is up
  assign ctl.core_on = (state != SEQ_OFF);
  assign ctl.buf_on  = (state != SEQ_OFF) && ctl.buf_bit;
  assign ctl.warming = (state == SEQ_WARM);
  assign ctl.ready   = (state == SEQ_RUN);
endmodule
`default_nettype wire

// >>> dac_core_model.sv
// Behavioural model of the analog core and its pin buffer.
// Assumes the control block drives power, code and start on one clock.
`timescale 1ns/1ps
`default_nettype none
module dac_core_model (
  input  wire logic                       clk,     // Clock
  input  wire logic                       rst,     // Sync reset, high
  input  wire logic                       core_on, // Core power
  input  wire logic                       buf_on,  // Buffer power
  input  wire logic [dac_pkg::CODE_W-1:0] code,    // Code in
  input  wire logic                       start,   // Convert pulse
  output logic      [dac_pkg::CODE_W-1:0] level,   // Internal output
  output logic      [dac_pkg::CODE_W-1:0] pin,     // Pin level
  output int                              n_conv   // Conversions made
);
  import dac_pkg::*;
  logic [CODE_W-1:0] held; // Last converted code

  // A conversion only lands while the core is powered
  always_ff @(posedge clk) begin
    if (rst) begin
      held   <= '0;
      n_conv <= 0;
    end else if (start && core_on) begin
      held   <= code;
      n_conv <= n_conv + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Unpowered nodes show the inverse so a stale value never passes
  assign level = core_on ? held : ~held;
  // Software has turned the pin's digital input off before this drives it
  assign pin   = buf_on ? held : ~held;
endmodule
`default_nettype wire

// >>> dac_control_checker.sv
// Concurrent checks on the converter control block ports.
// Assumes it is bound into dac_control_logic; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module dac_control_checker #(
  parameter int ADR_W      = 8,    // Byte address width
  parameter int STARTUP_NS = 1000  // Start-up time
) (
  input wire logic                       MCLK,           // Clock
  input wire logic                       RESET,          // Reset
  input wire logic [ADR_W-1:0]           WB_ADR_I,       // Address
  input wire logic [31:0]                WB_DAT_I,       // Write data
  input wire logic [31:0]                WB_DAT_O,       // Read data
  input wire logic [3:0]                 WB_SEL_I,       // Lanes
  input wire logic                       WB_WE_I,        // Write
  input wire logic                       WB_STB_I,       // Strobe
  input wire logic                       WB_CYC_I,       // Cycle
  input wire logic                       WB_ACK_O,       // Ack
  input wire logic                       WB_ERR_O,       // Error
  input wire logic                       STANDBY_REQ,    // Standby
  input wire logic                       POWERDOWN_REQ,  // Power-down
  input wire logic                       CORE_ON,        // Core power
  input wire logic                       BUFFER_ON,      // Buffer power
  input wire logic                       INTERNAL_READY, // Ready
  input wire logic [dac_pkg::CODE_W-1:0] CODE_OUT,       // Code
  input wire logic                       CONV_START      // Start
);
  import dac_pkg::*;
  logic [7:0] ctl; // Mirror of the control register

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);

  // Mirror follows acknowledged writes; unmapped ones get ERR instead
  always_ff @(posedge MCLK) begin
    if (RESET)
      ctl <= 8'h00;
    else if (WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0]
             && WB_ADR_I[ADR_W-1:2] == '0)
      ctl <= WB_DAT_I[7:0] & CTL_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // Power, start-up and conversion relations
  a_buf_follows: assert property (BUFFER_ON == (CORE_ON && ctl[6]))
    else $error("buffer power differs from core and buffer bit");
  a_ready_core: assert property (INTERNAL_READY |-> CORE_ON)
    else $error("ready without core power");
  a_start_core: assert property (CONV_START |-> CORE_ON)
    else $error("conversion started with core off");
  a_warm_wait: assert property ($rose(CORE_ON) |-> !INTERNAL_READY [*8])
    else $error("ready before start-up interval");
  a_pd_off: assert property (POWERDOWN_REQ [*5] |-> !CORE_ON)
    else $error("core on in power-down");
  a_sb_stop: assert property ((STANDBY_REQ && !ctl[7]) [*5]
    |-> !CORE_ON && !BUFFER_ON)
    else $error("core or buffer on in standby stop");
  a_sb_keep: assert property ((ctl[0] && ctl[7] && !POWERDOWN_REQ) [*6]
    |-> CORE_ON)
    else $error("core off while enabled with standby run");
  a_off_core: assert property (!ctl[0] [*2] |-> !CORE_ON)
    else $error("core on while on bit clear");
  a_code_moves: assert property ($changed(CODE_OUT) |-> CONV_START)
    else $error("code output changed without a start");

  c_start: cover property (CONV_START);
  c_sb_run: cover property (STANDBY_REQ && ctl[7] && CORE_ON);
  c_pd_off: cover property (POWERDOWN_REQ && !CORE_ON);
endmodule

bind dac_control_logic dac_control_checker #(
  .ADR_W(ADR_W), .STARTUP_NS(STARTUP_NS)
) u_chk (
  .MCLK(MCLK), .RESET(RESET), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I),
  .WB_DAT_O(WB_DAT_O), .WB_SEL_I(WB_SEL_I), .WB_WE_I(WB_WE_I),
  .WB_STB_I(WB_STB_I), .WB_CYC_I(WB_CYC_I), .WB_ACK_O(WB_ACK_O),
  .WB_ERR_O(WB_ERR_O), .STANDBY_REQ(STANDBY_REQ),
  .POWERDOWN_REQ(POWERDOWN_REQ), .CORE_ON(CORE_ON), .BUFFER_ON(BUFFER_ON),
  .INTERNAL_READY(INTERNAL_READY), .CODE_OUT(CODE_OUT),
  .CONV_START(CONV_START)
);
`default_nettype wire

// >>> testbench.sv
// Self-checking bench: Wishbone register tasks and sleep stimulus.
// Assumes the core model beside the block and a 250 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import dac_pkg::*;
  localparam int SU_NS = 40;        // Short start-up keeps the run brief
  localparam int WARM  = SU_NS / 4; // Start-up cycles at 4 ns
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0;
  logic [31:0]       dat_o;
  logic [3:0]        sel = 4'h0;
  logic              we = 1'b0;
  logic              stb = 1'b0;
  logic              cyc = 1'b0;
  logic              ack;
  logic              err_o;
  logic              standby = 1'b0;
  logic              powerdown = 1'b0;
  logic              core_on;
  logic              buffer_on;
  logic              ready;
  logic [CODE_W-1:0] code;
  logic              start;
  logic [CODE_W-1:0] level;
  logic [CODE_W-1:0] pin;
  int                n_conv;
  int                n_fail = 0;
  int                checked = 0;

  always #2 mclk = ~mclk;

  dac_control_logic #(.ADR_W(8), .STARTUP_NS(SU_NS)) uut (
    .MCLK(mclk), .RESET(reset), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(dat_o), .WB_SEL_I(sel), .WB_WE_I(we), .WB_STB_I(stb),
    .WB_CYC_I(cyc), .WB_ACK_O(ack), .WB_ERR_O(err_o),
    .STANDBY_REQ(standby), .POWERDOWN_REQ(powerdown), .CORE_ON(core_on),
    .BUFFER_ON(buffer_on), .INTERNAL_READY(ready), .CODE_OUT(code),
    .CONV_START(start)
  );
  dac_core_model u_core (
    .clk(mclk), .rst(reset), .core_on(core_on), .buf_on(buffer_on),
    .code(code), .start(start), .level(level), .pin(pin), .n_conv(n_conv)
  );

  ////////////////////////////////////////////////////////////////////////
  // Verdict, comparison and bus tasks
  task automatic stop_test;
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Request held until ack or err is seen at a rising edge; only the
  // watchdog ends a wait that never gets an answer
  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] rd,
                    output logic e);
    @(posedge mclk);
    adr  <= a;
    we   <= w;
    wdat <= d;
    sel  <= s;
    cyc  <= 1'b1;
    stb  <= 1'b1;
    do
      @(posedge mclk);
    while (ack !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    e  = err_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] rd;
    logic        e;
    wb(a, 1'b1, d, s, rd, e);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    wb(a, 1'b0, 32'h0, 4'hF, rd, e);
    check(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Main sequence: store, enable, byte writes, standby, power-down, off
  initial begin
    logic [31:0] d;
    logic        e;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    rdchk(8'h00, 32'h0);
    rdchk(8'h08, 32'h0);
    wr(8'h08, 32'hFFFF, 4'h3);
    idle(4);
    check(n_conv, 0);
    rdchk(8'h08, 32'hFFC0);
    wr(8'h00, 32'hFF, 4'h1);
    rdchk(8'h00, 32'hC1);
    idle(WARM + 6);
    check(n_conv, 1);
    check(level, 10'h3FF);
    check(pin, 10'h3FF);
    check(ready, 1'b1);
    rdchk(8'h0C, 32'h07);
    wr(8'h08, 32'h0080, 4'h1);
    idle(4);
    check(n_conv, 1);
    wr(8'h08, 32'h5500, 4'h2);
    idle(4);
    check(n_conv, 2);
    check(level, 10'h156);
    standby <= 1'b1;
    idle(8);
    check(core_on, 1'b1);
    check(buffer_on, 1'b1);
    wr(8'h00, 32'h41, 4'h1);
    idle(6);
    check(core_on, 1'b0);
    check(buffer_on, 1'b0);
    wr(8'h00, 32'h01, 4'h1);
    standby <= 1'b0;
    idle(5);
    check(core_on, 1'b1);
    check(buffer_on, 1'b0);
    check(ready, 1'b0);
    check(n_conv, 2);
    rdchk(8'h0C, 32'h09);
    idle(WARM + 4);
    check(n_conv, 3);
    check(level, 10'h156);
    wr(8'h00, 32'hC1, 4'h1);
    idle(4);
    powerdown <= 1'b1;
    idle(6);
    check(core_on, 1'b0);
    check(buffer_on, 1'b0);
    powerdown <= 1'b0;
    idle(WARM + 8);
    check(n_conv, 4);
    wr(8'h00, 32'h00, 4'h1);
    idle(3);
    check(core_on, 1'b0);
    check(ready, 1'b0);
    wr(8'h08, 32'h1234, 4'h3);
    idle(4);
    check(n_conv, 4);
    wb(8'h40, 1'b0, 32'h0, 4'hF, d, e);
    check(e, 1'b1);
    check(d, 32'h0);
    stop_test;
  end

  // Watchdog cuts a hung handshake short
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    stop_test;
  end
endmodule
`default_nettype wire
